// ===== design/dpmu_pkg.sv
// package for the upper code point priority map: widths, register indices,
// field layout and the struct carriers shared by the map and its bench.
// assumes a 32-bit avalon-mm register bus with byte addresses.
package dpmu_pkg;

  // classifier side widths
  localparam int DSCP_W = 6;
  localparam int PRIO_W = 3;
  // number of mapping registers in this slice of the table
  localparam int REG_COUNT = 11;
  localparam int IDX_W = 4;

  // bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [9:0] DSCP_PRIO_MAP_2A_2B_IDX = 10'h355;
  localparam logic [9:0] DSCP_PRIO_MAP_2C_2D_IDX = 10'h356;
  localparam logic [9:0] DSCP_PRIO_MAP_2E_2F_IDX = 10'h357;
  localparam logic [9:0] DSCP_PRIO_MAP_30_31_IDX = 10'h358;
  localparam logic [9:0] DSCP_PRIO_MAP_32_33_IDX = 10'h359;
  localparam logic [9:0] DSCP_PRIO_MAP_34_35_IDX = 10'h35A;
  localparam logic [9:0] DSCP_PRIO_MAP_36_37_IDX = 10'h35B;
  localparam logic [9:0] DSCP_PRIO_MAP_38_39_IDX = 10'h35C;
  localparam logic [9:0] DSCP_PRIO_MAP_3A_3B_IDX = 10'h35D;
  localparam logic [9:0] DSCP_PRIO_MAP_3C_3D_IDX = 10'h35E;
  localparam logic [9:0] DSCP_PRIO_MAP_3E_3F_IDX = 10'h35F;
  // table base is the first register of this slice
  localparam logic [9:0] MAP_BASE_IDX = DSCP_PRIO_MAP_2A_2B_IDX;
  // byte-lane offset bits below the index
  localparam int LANE_BITS = 2;

  // first code point covered, and its pair number (code point >> 1)
  localparam logic [DSCP_W-1:0] FIRST_CODE = 6'h2A;
  localparam logic [DSCP_W-2:0] FIRST_PAIR = 5'h15;

  // field layout inside each 8-bit mapping register
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 4;
  localparam int RSVD_LO_BIT = 3;
  localparam int RSVD_HI_BIT = 7;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;

  // code point lookup request from the classifier
  typedef struct packed {
    logic valid;
    logic [DSCP_W-1:0] code;
  } dpmu_req_t;

  // lookup answer, one cycle after the request
  typedef struct packed {
    logic valid;
    logic hit;
    logic [PRIO_W-1:0] prio;
  } dpmu_resp_t;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } dpmu_bus_state_t;

endpackage : dpmu_pkg

// ===== design/dpmu_map_upper.sv
// code point to priority map, upper slice (0x2A..0x3F), avalon-mm slave.
// assumes the request input comes from logic on mclk and that the bus
// master holds each request until it sees waitrequest low.
// Notes on behaviour
// - 0x2A low field, 0x2B high, first register
// - 0x2C, 0x2D from second register fields
// - 0x2E, 0x2F from register 0x0357
// - 0x30, 0x31 from register 0x0358
// - 0x32, 0x33 from register 0x0359
// - 0x34, 0x35 from register 0x035A
// - 0x36, 0x37 from register 0x035B
// - 0x38, 0x39 from register 0x035C
// - 0x3A, 0x3B from register 0x035D
// - 0x3C, 0x3D from register 0x035E
// - 0x3E, 0x3F from register 0x035F
// - bits 7 and 3 read zero, ignore writes
// - priority fields read/write, reset to zero
`timescale 1ns/100ps
module dpmu_map_upper (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [dpmu_pkg::ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [dpmu_pkg::BE_W-1:0] avsByteenable,
  input wire logic [dpmu_pkg::DATA_W-1:0] avsWritedata,
  output logic [dpmu_pkg::DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  // classifier lookup
  input wire dpmu_pkg::dpmu_req_t lookupReq,
  output dpmu_pkg::dpmu_resp_t lookupResp
);
  import dpmu_pkg::*;

  // priority fields, one low and one high per register
  logic [PRIO_W-1:0] loField_reg [REG_COUNT];
  logic [PRIO_W-1:0] hiField_reg [REG_COUNT];
  // bus state and registered read data
  dpmu_bus_state_t busState_reg;
  dpmu_bus_state_t busState_next;
  logic [DATA_W-1:0] readData_reg;
  // lookup answer register
  dpmu_resp_t resp_reg;

  // decode a byte address: hit flag and table slot
  function automatic logic [IDX_W:0] decodeAddr(input logic [ADDR_W-1:0] addr);
    logic [9:0] wordIdx;
    logic [9:0] slot;
    wordIdx = addr[ADDR_W-1:LANE_BITS];
    slot = wordIdx - MAP_BASE_IDX;
    if (addr[LANE_BITS-1:0] == 2'h0 && wordIdx >= MAP_BASE_IDX &&
        slot < 10'(REG_COUNT)) begin
      decodeAddr = {1'b1, slot[IDX_W-1:0]};
    end else begin
      decodeAddr = {1'b0, {IDX_W{1'b0}}};
    end
  endfunction : decodeAddr

  // bus decode, shared by read and write paths
  logic [IDX_W:0] busDec;
  logic busHit;
  logic [IDX_W-1:0] busSlot;
  logic busReq;
  logic busCommit;
  assign busDec = decodeAddr(avsAddress);
  assign busHit = busDec[IDX_W];
  assign busSlot = busDec[IDX_W-1:0];
  assign busReq = avsRead | avsWrite;
  // the edge where waitrequest is sampled low is the commit edge
  assign busCommit = busReq && (busState_reg == BUS_ACK);
  assign avsWaitrequest = busReq && (busState_reg != BUS_ACK);
  assign avsReaddata = readData_reg;

  // one wait state per access: idle sees the request, ack completes it
  always_comb begin
    case (busState_reg)
      BUS_IDLE: busState_next = busReq ? BUS_ACK : BUS_IDLE;
      BUS_ACK: busState_next = BUS_IDLE;
      default: busState_next = BUS_IDLE;
    endcase
  end

  // bus state register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busState_reg <= BUS_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // read data is captured in the wait cycle so it stands at the commit edge;
  // reserved bits and unmapped words read as zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      readData_reg <= 32'h0000_0000;
    end else if (avsRead && busState_reg == BUS_IDLE) begin
      if (busHit) begin
        readData_reg <= {24'h00_0000, 1'b0, hiField_reg[busSlot],
                         1'b0, loField_reg[busSlot]};
      end else begin
        readData_reg <= 32'h0000_0000;
      end
    end
  end

  // field storage; writes land on the commit edge through byte lane 0 only,
  // so a stray upper-lane write can never disturb the table
  generate
    for (genvar gi = 0; gi < REG_COUNT; gi++) begin : g_field
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          loField_reg[gi] <= PRIO_RESET;
          hiField_reg[gi] <= PRIO_RESET;
        end else if (busCommit && avsWrite && busHit && avsByteenable[0] &&
                     busSlot == IDX_W'(gi)) begin
          // bits 3 and 7 are simply not stored
          loField_reg[gi] <= avsWritedata[LO_LSB +: PRIO_W];
          hiField_reg[gi] <= avsWritedata[HI_LSB +: PRIO_W];
        end
      end
    end
  endgenerate

  // lookup: pair number minus the base pair gives the slot, parity the field
  logic [DSCP_W-2:0] pairRel;
  logic codeHit;
  logic [IDX_W-1:0] codeSlot;
  assign codeHit = (lookupReq.code >= FIRST_CODE);
  assign pairRel = lookupReq.code[DSCP_W-1:1] - FIRST_PAIR;
  assign codeSlot = pairRel[IDX_W-1:0];

  // registered answer; codes below this slice answer with hit low, prio zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      resp_reg <= '0;
    end else begin
      resp_reg.valid <= lookupReq.valid;
      resp_reg.hit <= lookupReq.valid && codeHit;
      if (lookupReq.valid && codeHit) begin
        resp_reg.prio <= lookupReq.code[0] ? hiField_reg[codeSlot]
                                           : loField_reg[codeSlot];
      end else begin
        resp_reg.prio <= PRIO_RESET;
      end
    end
  end
  assign lookupResp = resp_reg;

  // code point to field check: answer one cycle later equals the field
  property p_map(logic [DSCP_W-1:0] c, int slot);
    @(posedge mclk) disable iff (!rstn)
    (lookupReq.valid && lookupReq.code == c) |=>
      (lookupResp.valid && lookupResp.hit &&
       lookupResp.prio == (c[0] ? $past(hiField_reg[slot]) : $past(loField_reg[slot])));
  endproperty

  a_map_2a: assert property (p_map(6'h2A, 0)) else $error("0x2A mis-mapped");
  a_map_2b: assert property (p_map(6'h2B, 0)) else $error("0x2B mis-mapped");
  a_map_2c: assert property (p_map(6'h2C, 1)) else $error("0x2C mis-mapped");
  a_map_2d: assert property (p_map(6'h2D, 1)) else $error("0x2D mis-mapped");
  a_map_2e: assert property (p_map(6'h2E, 2)) else $error("0x2E mis-mapped");
  a_map_2f: assert property (p_map(6'h2F, 2)) else $error("0x2F mis-mapped");
  a_map_30: assert property (p_map(6'h30, 3)) else $error("0x30 mis-mapped");
  a_map_31: assert property (p_map(6'h31, 3)) else $error("0x31 mis-mapped");
  a_map_32: assert property (p_map(6'h32, 4)) else $error("0x32 mis-mapped");
  a_map_33: assert property (p_map(6'h33, 4)) else $error("0x33 mis-mapped");
  a_map_34: assert property (p_map(6'h34, 5)) else $error("0x34 mis-mapped");
  a_map_35: assert property (p_map(6'h35, 5)) else $error("0x35 mis-mapped");
  a_map_36: assert property (p_map(6'h36, 6)) else $error("0x36 mis-mapped");
  a_map_37: assert property (p_map(6'h37, 6)) else $error("0x37 mis-mapped");
  a_map_38: assert property (p_map(6'h38, 7)) else $error("0x38 mis-mapped");
  a_map_39: assert property (p_map(6'h39, 7)) else $error("0x39 mis-mapped");
  a_map_3a: assert property (p_map(6'h3A, 8)) else $error("0x3A mis-mapped");
  a_map_3b: assert property (p_map(6'h3B, 8)) else $error("0x3B mis-mapped");
  a_map_3c: assert property (p_map(6'h3C, 9)) else $error("0x3C mis-mapped");
  a_map_3d: assert property (p_map(6'h3D, 9)) else $error("0x3D mis-mapped");
  a_map_3e: assert property (p_map(6'h3E, 10)) else $error("0x3E mis-mapped");
  a_map_3f: assert property (p_map(6'h3F, 10)) else $error("0x3F mis-mapped");

  // write then read back through the bus: reserved bits zero, fields kept
  sequence s_write_hit;
    avsWrite && !avsWaitrequest && busHit && avsByteenable[0];
  endsequence
  sequence s_read_done;
    avsRead && !avsWaitrequest && busHit;
  endsequence

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
    s_read_done |-> (avsReaddata[RSVD_HI_BIT] == 1'b0 &&
      avsReaddata[RSVD_LO_BIT] == 1'b0 && avsReaddata[DATA_W-1:REG_W] == 24'h00_0000))
    else $error("reserved read bits not zero");
  a_field_store: assert property (@(posedge mclk) disable iff (!rstn)
    s_write_hit |=> (loField_reg[$past(busSlot)] == $past(avsWritedata[LO_LSB +: PRIO_W]) &&
      hiField_reg[$past(busSlot)] == $past(avsWritedata[HI_LSB +: PRIO_W])))
    else $error("priority field write lost");
  a_reset_zero: assert property (@(posedge mclk)
    !rstn |=> (loField_reg[0] == PRIO_RESET && hiField_reg[REG_COUNT-1] == PRIO_RESET))
    else $error("priority field not zero after reset");
  a_bus_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (busReq && busState_reg == BUS_IDLE) |=> (busReq |-> !avsWaitrequest))
    else $error("bus answer not after one wait cycle");
  a_slot_select: assert property (@(posedge mclk) disable iff (!rstn)
    (lookupReq.valid && codeHit) |-> (32'(codeSlot) < REG_COUNT &&
      {1'b0, codeSlot} == 5'(lookupReq.code[DSCP_W-1:1] - FIRST_PAIR)))
    else $error("slot not base plus code shifted");

  // helper for the hold checks: a write that really lands in the table.
  // kept apart from the storage enable so a broken enable still shows up
  logic wrLands;
  assign wrLands = avsWrite && !avsWaitrequest && busHit && avsByteenable[0];

  // lookup for a code below this slice; the lower table answers for it
  sequence s_low_req;
    lookupReq.valid && !codeHit;
  endsequence

  // lookup for a code inside this slice
  sequence s_slice_req;
    lookupReq.valid && codeHit;
  endsequence

  // a bus request first seen in the idle state
  sequence s_bus_take;
    busReq && busState_reg == BUS_IDLE;
  endsequence

  // a request that is still up in the answer state
  sequence s_bus_ack;
    busReq && busState_reg == BUS_ACK;
  endsequence

  // codes below the slice answer with hit low and priority zero
  a_low_miss: assert property (@(posedge mclk) disable iff (!rstn)
    s_low_req |=> (lookupResp.valid && !lookupResp.hit && lookupResp.prio == PRIO_RESET))
    else $error("code below slice answered as a hit");

  // codes inside the slice always answer with hit high
  a_slice_hit: assert property (@(posedge mclk) disable iff (!rstn)
    s_slice_req |=> (lookupResp.valid && lookupResp.hit))
    else $error("code inside slice answered as a miss");

  // no request, no answer: the classifier must never see a stale result
  a_resp_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !lookupReq.valid |=> (!lookupResp.valid && !lookupResp.hit &&
      lookupResp.prio == PRIO_RESET))
    else $error("answer without a request");

  // every new request waits exactly one cycle
  a_first_wait: assert property (@(posedge mclk) disable iff (!rstn)
    s_bus_take |-> avsWaitrequest)
    else $error("request answered without a wait cycle");

  // in the answer state the request is never held off
  a_ack_ready: assert property (@(posedge mclk) disable iff (!rstn)
    s_bus_ack |-> !avsWaitrequest)
    else $error("request held off in answer state");

  // waitrequest only rises while a request stands
  a_wait_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    !busReq |-> !avsWaitrequest)
    else $error("waitrequest without a request");

  // the answer state lasts one cycle, so back to back requests each wait
  a_ack_short: assert property (@(posedge mclk) disable iff (!rstn)
    busState_reg == BUS_ACK |=> busState_reg == BUS_IDLE)
    else $error("answer state held over");

  // the state register stays one-hot
  a_state_onehot: assert property (@(posedge mclk) disable iff (!rstn)
    $onehot(busState_reg))
    else $error("bus state not one-hot");

  // read data carries the fields as they stood in the wait cycle
  a_read_fields: assert property (@(posedge mclk) disable iff (!rstn)
    s_read_done |-> (avsReaddata[LO_LSB +: PRIO_W] == $past(loField_reg[busSlot]) &&
      avsReaddata[HI_LSB +: PRIO_W] == $past(hiField_reg[busSlot])))
    else $error("read data does not match the fields");

  // words outside the slice, or misaligned, read as zero
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rstn)
    (avsRead && !avsWaitrequest && !busHit) |-> avsReaddata == 32'h0000_0000)
    else $error("unmapped word read not zero");

  // the read register never holds a reserved bit, whatever was written
  a_rsvd_store: assert property (@(posedge mclk) disable iff (!rstn)
    (readData_reg[RSVD_HI_BIT] == 1'b0 && readData_reg[RSVD_LO_BIT] == 1'b0 &&
      readData_reg[DATA_W-1:REG_W] == 24'h00_0000))
    else $error("reserved bit stored in read data");

  // read data only moves when a new read is taken
  a_read_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !(avsRead && busState_reg == BUS_IDLE) |=> $stable(readData_reg))
    else $error("read data moved without a read");

  // per slot: a field only changes when a write lands in its own slot,
  // which also covers refused lanes, misaligned and unmapped writes
  generate
    for (genvar gk = 0; gk < REG_COUNT; gk++) begin : g_field_chk
      a_field_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !(wrLands && busSlot == IDX_W'(gk)) |=>
          ($stable(loField_reg[gk]) && $stable(hiField_reg[gk])))
        else $error("priority field changed without a write");
      // every slot, not only the two ends, returns to zero
      a_slot_reset: assert property (@(posedge mclk)
        !rstn |=> (loField_reg[gk] == PRIO_RESET && hiField_reg[gk] == PRIO_RESET))
        else $error("slot not zero after reset");
    end
  endgenerate

endmodule : dpmu_map_upper

// ===== verification/tb_dpmu_map_upper.sv
// self-checking bench for the upper code point priority map.
// assumes the dpmu_pkg package and the map module are compiled first.
`timescale 1ns/100ps
module tb_dpmu_map_upper;
  import dpmu_pkg::*;
  // clock, reset and ports
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [BE_W-1:0] avsByteenable = '0;
  logic [DATA_W-1:0] avsWritedata = '0;
  logic [DATA_W-1:0] avsReaddata;
  logic avsWaitrequest;
  dpmu_req_t lookupReq = '0;
  dpmu_resp_t lookupResp;
  // bench state: shadow copy of the table, expectation queues, counters
  logic [7:0] shadowMem [0:REG_COUNT-1];
  logic [31:0] expRd [$];
  dpmu_resp_t expLk [$];
  int fail_count = 0;
  int n_tests = 0;
  integer seed = 32'h2A3F;

  dpmu_map_upper dut_u (.mclk(mclk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .lookupReq(lookupReq),
    .lookupResp(lookupResp));

  // 125 MHz clock
  always #4 mclk = ~mclk;

  // one comparison; case inequality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // register slot of a byte address, or -1 when unmapped or misaligned
  function automatic int slot(input logic [11:0] a);
    int k;
    k = int'(a[11:2]) - 'h355;
    return (a[1:0] == 2'h0 && k >= 0 && k < 11) ? k : -1;
  endfunction : slot

  // expected lookup answer worked out from the shadow table
  function automatic dpmu_resp_t exp_look(input logic [5:0] c);
    logic [7:0] r;
    logic hit;
    hit = (c >= 6'h2A);
    r = hit ? shadowMem[int'(c[5:1]) - 'h15] : 8'h00;
    return '{valid: 1'b1, hit: hit, prio: hit ? (c[0] ? r[6:4] : r[2:0]) : 3'h0};
  endfunction : exp_look

  // monitor: a result takes the oldest note off its queue
  always @(posedge mclk) begin
    if (rstn && avsRead && avsWaitrequest === 1'b0) begin
      chk(avsReaddata, (expRd.size() > 0) ? expRd.pop_front() : 32'hDEAD_BEEF);
    end
    if (lookupResp.valid === 1'b1) begin
      chk({27'h0, lookupResp}, (expLk.size() > 0) ? {27'h0, expLk.pop_front()} : 32'hFF);
    end
  end

  // synchronous reset for eight cycles; the table returns to zero
  task automatic do_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    foreach (shadowMem[i]) shadowMem[i] = 8'h00;
  endtask : do_reset

  // one avalon-mm transfer, held until waitrequest is seen low at a rising edge
  task automatic bus_op(input logic wr, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    int k;
    int n;
    k = slot(a);
    n = 0;
    if (!wr) expRd.push_back((k >= 0) ? {24'h0, shadowMem[k]} : 32'h0);
    else if (be[0] && k >= 0) shadowMem[k] = d[7:0] & 8'h77;
    @(posedge mclk);
    avsAddress <= a;
    avsRead <= !wr;
    avsWrite <= wr;
    avsByteenable <= be;
    avsWritedata <= d;
    // the request stands until a rising edge samples waitrequest low; data is taken there
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("[FAIL] t=%0t waitrequest=%h exp=%h", $time, avsWaitrequest, 1'b0);
    end
  endtask : bus_op

  // one lookup per cycle; the caller ends a burst with look_idle
  task automatic look_one(input logic [5:0] c);
    @(posedge mclk);
    lookupReq <= '{valid: 1'b1, code: c};
    expLk.push_back(exp_look(c));
  endtask : look_one

  // drop valid and let the last answers drain
  task automatic look_idle();
    @(posedge mclk);
    lookupReq.valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : look_idle

  // read every register, then look up every code point 0x20..0x3F back to back
  task automatic sweep();
    for (int i = 0; i < 11; i++) bus_op(1'b0, 12'hD54 + 12'(4 * i), 4'hF, 32'h0);
    for (int c = 'h20; c < 'h40; c++) look_one(6'(c));
    look_idle();
  endtask : sweep

  // verdict, reached from the main sequence or from the watchdog
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    do_reset();
    sweep();
    // random programming, reserved bits included in the written data
    for (int i = 0; i < 11; i++) bus_op(1'b1, 12'hD54 + 12'(4 * i), 4'h1, $random(seed));
    bus_op(1'b1, 12'hD7C, 4'h1, 32'hFFFF_FFFF);
    sweep();
    for (int i = 0; i < 40; i++) look_one(6'($random(seed)));
    look_idle();
    // refused writes: lane 0 disabled, misaligned, unmapped; then a reserved-bits-only write and two unmapped reads
    bus_op(1'b1, 12'hD54, 4'hE, 32'hFFFF_FFFF);
    bus_op(1'b1, 12'hD55, 4'hF, 32'hFFFF_FFFF);
    bus_op(1'b1, 12'hD80, 4'hF, 32'hFFFF_FFFF);
    bus_op(1'b1, 12'hD58, 4'h1, 32'h0000_0088);
    bus_op(1'b0, 12'hD50, 4'hF, 32'h0);
    bus_op(1'b0, 12'hD80, 4'hF, 32'h0);
    sweep();
    // second reset in mid-run clears every field
    do_reset();
    sweep();
    conclude();
  end

  // watchdog well beyond the roughly 400 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule : tb_dpmu_map_upper
